// *** core/upa_pkg.sv ***
// Package for the pin, loopback, infrared, clock-out and wake configuration bank.
// Assumes a 200 MHz system clock and a 16-bit plain register port.
package upa_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_DRIVE    = 6'h13;
    localparam logic [5:0] IDX_PULLUP   = 6'h14;
    localparam logic [5:0] IDX_PULLDOWN = 6'h15;
    localparam logic [5:0] IDX_LOOP     = 6'h16;
    localparam logic [5:0] IDX_IR       = 6'h17;
    localparam logic [5:0] IDX_CLKOUT   = 6'h18;
    localparam logic [5:0] IDX_WAKE_SEL = 6'h1F;
    localparam logic [5:0] IDX_WAKE_STS = 6'h20;

    // Reset values
    localparam logic [15:0] RST_DRIVE    = 16'h0080;
    localparam logic [15:0] RST_PULLUP   = 16'h07FF;
    localparam logic [15:0] RST_PULLDOWN = 16'h0000;
    localparam logic [15:0] RST_LOOP     = 16'h0000;
    localparam logic [15:0] RST_IR       = 16'h0000;
    localparam logic [15:0] RST_CLKOUT   = 16'h0000;
    localparam logic [15:0] RST_WAKE_SEL = 16'h0004;

    // Writable bits of each register; reserved bits stay zero
    localparam logic [15:0] MSK_DRIVE    = 16'h0BFF;
    localparam logic [15:0] MSK_PULL     = 16'h07FF;
    localparam logic [15:0] MSK_LOOP     = 16'h0007;
    localparam logic [15:0] MSK_IR       = 16'h0007;
    localparam logic [15:0] MSK_WAKE_SEL = 16'h000C;
    localparam logic [15:0] MSK_WAKE_STS = 16'h000C;

    // Field positions
    localparam int DRV_TX_BIT     = 11;
    localparam int PULL_RX_BIT    = 10;
    localparam int LOOP_DTR_BIT   = 2;
    localparam int LOOP_RTS_BIT   = 1;
    localparam int LOOP_DATA_BIT  = 0;
    localparam int IR_PULSE_BIT   = 2;
    localparam int IR_INVERT_BIT  = 1;
    localparam int IR_EN_BIT      = 0;
    localparam int CLK_HI_LSB     = 8;
    localparam int CLK_LO_LSB     = 0;
    localparam int WAKE_RX_BIT    = 3;
    localparam int WAKE_RING_BIT  = 2;

    // Infrared timing in sixteenths of a bit
    localparam logic [3:0] IR_PULSE_NARROW = 4'h3;
    localparam logic [3:0] IR_PULSE_WIDE   = 4'h4;
    localparam logic [4:0] IR_BIT_TICKS    = 5'h10;

    // Clock-out interval and its rate, derived for a fractional tick generator
    localparam real CLKOUT_INTERVAL_NS = 41.67;
    localparam int  SYS_CLK_KHZ        = 200000;
    localparam int  CLKOUT_TICK_KHZ    = int'(1.0e6 / CLKOUT_INTERVAL_NS);

    typedef struct packed {
        logic [9:0] out;
        logic [9:0] oe;
        logic [9:0] pull_up;
        logic [9:0] pull_down;
    } upa_gpio_pad_t;

    typedef struct packed {
        logic out;
        logic oe;
    } upa_pin_drive_t;
endpackage

// *** core/upa_pin_config.sv ***
// Configuration bank: pin drive type, pulls, loopback, infrared, clock out, wake.
// Assumes pin muxing, GPIO direction and the UART core lie outside, on clk_sys;
// pad inputs arrive asynchronously and are synchronised here.
//
// Function
// - Bit 11 selects TX push-pull or open drain.
// - Bits 9:0 select GPIO output drive type.
// - GPIO7 drive type resets to open drain.
// - Drive type applies to TX and GPIO output pins only.
// - Bit 10 enables RX pull-up, reset on.
// - Bits 9:0 enable GPIO pull-ups, reset on.
// - Pull-down bits for RX and GPIO, reset off.
// - Both selected means pull-up only.
// - Pulls apply to RX and GPIO input pins only.
// - Loop bit 2 feeds DTR into DSR.
// - Loop bit 1 feeds RTS into CTS.
// - Loop bit 0 feeds TX into receiver.
// - Data loopback idles TX pin, ignores RX.
// - Infrared pulse is 3/16 or 4/16 bit.
// - Infrared bit 1 inverts received data.
// - Infrared bit 0 enables infrared coding.
// - Bits 15:8 set clock-out high intervals.
// - Bits 7:0 set clock-out low intervals.
// - Wake bit 3: RX falling edge wakes.
// - Wake bit 2: ring pin falling edge wakes.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module upa_pin_config #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    input  wire logic                   clk_sys,         // System clock, 200 MHz
    input  wire logic                   rst,             // Synchronous reset, high
    input  wire logic [ADDR_W-1:0]      reg_addr,        // Byte address
    input  wire logic [DATA_W-1:0]      reg_wdata,       // Write data
    input  wire logic                   reg_wr,          // Write strobe
    input  wire logic                   reg_rd,          // Read strobe
    output logic      [DATA_W-1:0]      reg_rdata,       // Read data, cycle after strobe
    input  wire logic [9:0]             gpio_dir,        // GPIO is output when 1
    input  wire logic [9:0]             gpio_level,      // Level wanted on each GPIO
    input  wire logic [9:0]             gpio_pad_in,     // GPIO pad levels
    output upa_pkg::upa_gpio_pad_t      gpio_pad,        // GPIO pad drive and pulls
    output logic      [9:0]             gpio_in,         // Filtered GPIO levels
    input  wire logic                   tx_data,         // Serial data from transmitter
    input  wire logic                   ir_tick16,       // Sixteen per bit, pulse
    input  wire logic                   ir_bit_start,    // Start of each TX bit, pulse
    output upa_pkg::upa_pin_drive_t     tx_pad,          // TX pad drive
    input  wire logic                   rx_pad_in,       // RX pad level
    input  wire logic                   rx_is_input,     // RX pin used as input
    output logic                        rx_pull_up,      // RX pull-up enable
    output logic                        rx_pull_down,    // RX pull-down enable
    output logic                        rx_data,         // Serial data to receiver
    input  wire logic                   dtr_out,         // DTR from modem logic
    input  wire logic                   rts_out,         // RTS from modem logic
    input  wire logic                   dsr_pad_in,      // DSR pad level
    input  wire logic                   cts_pad_in,      // CTS pad level
    output logic                        dsr_in,          // DSR to modem logic
    output logic                        cts_in,          // CTS to modem logic
    input  wire logic                   ring_pad_in,     // Ring/wake pad level
    input  wire logic                   ring_is_input,   // Ring/wake pin used as input
    output logic                        wake_event,      // Remote-wakeup event, pulse
    output logic                        clock_out        // Generated output clock
);
    localparam int SYNC_W = 14;

    logic [15:0] drive_reg;
    logic [15:0] pullup_reg;
    logic [15:0] pulldown_reg;
    logic [15:0] loop_reg;
    logic [15:0] ir_reg;
    logic [15:0] clkdiv_reg;
    logic [15:0] wake_sel_reg;
    logic [15:0] wake_sts_reg;
    logic [15:0] wake_sts_next;

    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] filt_reg;
    logic [SYNC_W-1:0] filt_prev_reg;

    logic [5:0]  reg_idx;
    logic        addr_ok;
    logic        rx_filt;
    logic        ring_filt;
    logic        dsr_filt;
    logic        cts_filt;
    logic        rx_fall;
    logic        ring_fall;
    logic [1:0]  wake_hits;
    logic        loop_data;
    logic        ir_en;

    function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
        masked = d & m;
    endfunction

    // Open-drain drive only pulls low; high is left to the pull-up
    function automatic logic [1:0] drive(input logic lvl, input logic od, input logic en);
        drive = {od ? 1'b0 : lvl, en & (od ? ~lvl : 1'b1)};
    endfunction

    assign reg_idx   = reg_addr[7:2];
    assign addr_ok   = (reg_addr[1:0] == 2'h0);
    assign loop_data = loop_reg[upa_pkg::LOOP_DATA_BIT];
    assign ir_en     = ir_reg[upa_pkg::IR_EN_BIT];

    // Register writes; reserved bits are masked so they always read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drive_reg    <= upa_pkg::RST_DRIVE;
            pullup_reg   <= upa_pkg::RST_PULLUP;
            pulldown_reg <= upa_pkg::RST_PULLDOWN;
            loop_reg     <= upa_pkg::RST_LOOP;
            ir_reg       <= upa_pkg::RST_IR;
            clkdiv_reg   <= upa_pkg::RST_CLKOUT;
            wake_sel_reg <= upa_pkg::RST_WAKE_SEL;
        end else if (reg_wr && addr_ok) begin
            unique case (reg_idx)
                upa_pkg::IDX_DRIVE:    drive_reg    <= masked(reg_wdata, upa_pkg::MSK_DRIVE);
                upa_pkg::IDX_PULLUP:   pullup_reg   <= masked(reg_wdata, upa_pkg::MSK_PULL);
                upa_pkg::IDX_PULLDOWN: pulldown_reg <= masked(reg_wdata, upa_pkg::MSK_PULL);
                upa_pkg::IDX_LOOP:     loop_reg     <= masked(reg_wdata, upa_pkg::MSK_LOOP);
                upa_pkg::IDX_IR:       ir_reg       <= masked(reg_wdata, upa_pkg::MSK_IR);
                upa_pkg::IDX_CLKOUT:   clkdiv_reg   <= reg_wdata;
                upa_pkg::IDX_WAKE_SEL: wake_sel_reg <= masked(reg_wdata, upa_pkg::MSK_WAKE_SEL);
                default: begin
                end
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd && addr_ok) begin
            unique case (reg_idx)
                upa_pkg::IDX_DRIVE:    reg_rdata <= drive_reg;
                upa_pkg::IDX_PULLUP:   reg_rdata <= pullup_reg;
                upa_pkg::IDX_PULLDOWN: reg_rdata <= pulldown_reg;
                upa_pkg::IDX_LOOP:     reg_rdata <= loop_reg;
                upa_pkg::IDX_IR:       reg_rdata <= ir_reg;
                upa_pkg::IDX_CLKOUT:   reg_rdata <= clkdiv_reg;
                upa_pkg::IDX_WAKE_SEL: reg_rdata <= wake_sel_reg;
                upa_pkg::IDX_WAKE_STS: reg_rdata <= wake_sts_reg;
                default:               reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Pad inputs: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_reg     <= {SYNC_W{1'b1}};
            sync2_reg     <= {SYNC_W{1'b1}};
            sync3_reg     <= {SYNC_W{1'b1}};
            filt_reg      <= {SYNC_W{1'b1}};
            filt_prev_reg <= {SYNC_W{1'b1}};
        end else begin
            sync1_reg     <= {gpio_pad_in, rx_pad_in, ring_pad_in, dsr_pad_in, cts_pad_in};
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            filt_reg      <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
            filt_prev_reg <= filt_reg;
        end
    end

    assign rx_filt   = filt_reg[3];
    assign ring_filt = filt_reg[2];
    assign dsr_filt  = filt_reg[1];
    assign cts_filt  = filt_reg[0];
    assign rx_fall   = filt_prev_reg[3] & ~filt_reg[3];
    assign ring_fall = filt_prev_reg[2] & ~filt_reg[2];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpio_in <= 10'h3FF;
        end else begin
            gpio_in <= filt_reg[13:4];
        end
    end

    // GPIO pad drive and pulls; pin muxing upstream makes this cover alternate use too
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpio_pad <= '0;
        end else begin
            for (int i = 0; i < 10; i++) begin
                {gpio_pad.out[i], gpio_pad.oe[i]} <=
                    drive(gpio_level[i], drive_reg[i], gpio_dir[i]);
                gpio_pad.pull_up[i]   <= pullup_reg[i] & ~gpio_dir[i];
                gpio_pad.pull_down[i] <= pulldown_reg[i] & ~pullup_reg[i]
                                         & ~gpio_dir[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_pull_up   <= 1'b0;
            rx_pull_down <= 1'b0;
        end else begin
            rx_pull_up   <= pullup_reg[upa_pkg::PULL_RX_BIT] & rx_is_input;
            rx_pull_down <= pulldown_reg[upa_pkg::PULL_RX_BIT]
                            & ~pullup_reg[upa_pkg::PULL_RX_BIT] & rx_is_input;
        end
    end

    // Infrared transmit: position within the bit in sixteenths
    logic [3:0] ir_tx_phase_reg;
    logic       ir_tx_pulse;
    logic [3:0] ir_width;

    assign ir_width = ir_reg[upa_pkg::IR_PULSE_BIT] ? upa_pkg::IR_PULSE_WIDE
                                                    : upa_pkg::IR_PULSE_NARROW;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ir_tx_phase_reg <= 4'h0;
        end else if (ir_bit_start) begin
            ir_tx_phase_reg <= 4'h0;
        end else if (ir_tick16 && ir_tx_phase_reg != 4'hF) begin
            ir_tx_phase_reg <= ir_tx_phase_reg + 4'h1;
        end
    end

    // A zero bit is sent as one short high pulse, a one bit as no pulse
    assign ir_tx_pulse = ~tx_data & (ir_tx_phase_reg < ir_width);

    // TX pad; in data loopback the pad rests at the idle level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_pad <= '0;
        end else if (loop_data) begin
            {tx_pad.out, tx_pad.oe} <= drive(~ir_en, drive_reg[upa_pkg::DRV_TX_BIT],
                                             1'b1);
        end else if (ir_en) begin
            {tx_pad.out, tx_pad.oe} <= drive(ir_tx_pulse, drive_reg[upa_pkg::DRV_TX_BIT],
                                             1'b1);
        end else begin
            {tx_pad.out, tx_pad.oe} <= drive(tx_data, drive_reg[upa_pkg::DRV_TX_BIT],
                                             1'b1);
        end
    end

    // Infrared receive: each pulse stretches to a full zero bit
    logic       rx_line;
    logic       rx_line_prev_reg;
    logic [4:0] ir_rx_hold_reg;

    assign rx_line = rx_filt ^ ir_reg[upa_pkg::IR_INVERT_BIT];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_line_prev_reg <= 1'b0;
            ir_rx_hold_reg   <= 5'h00;
        end else begin
            rx_line_prev_reg <= rx_line;
            if (rx_line && !rx_line_prev_reg) begin
                ir_rx_hold_reg <= upa_pkg::IR_BIT_TICKS;
            end else if (ir_tick16 && ir_rx_hold_reg != 5'h00) begin
                ir_rx_hold_reg <= ir_rx_hold_reg - 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rx_data <= 1'b1;
        end else if (loop_data) begin
            rx_data <= tx_data;
        end else if (ir_en) begin
            rx_data <= ~(rx_line | (ir_rx_hold_reg != 5'h00));
        end else begin
            rx_data <= rx_line;
        end
    end

    // Modem handshake loopbacks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dsr_in <= 1'b0;
            cts_in <= 1'b0;
        end else begin
            dsr_in <= loop_reg[upa_pkg::LOOP_DTR_BIT] ? dtr_out : dsr_filt;
            cts_in <= loop_reg[upa_pkg::LOOP_RTS_BIT] ? rts_out : cts_filt;
        end
    end

    // Clock-out interval tick from a fractional accumulator on the system clock
    logic [17:0] tick_acc_reg;
    logic [18:0] tick_sum;
    logic        tick_en;

    assign tick_sum = {1'b0, tick_acc_reg} + 19'(upa_pkg::CLKOUT_TICK_KHZ);
    assign tick_en  = (tick_sum >= 19'(upa_pkg::SYS_CLK_KHZ));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_acc_reg <= 18'h00000;
        end else if (tick_en) begin
            tick_acc_reg <= 18'(tick_sum - 19'(upa_pkg::SYS_CLK_KHZ));
        end else begin
            tick_acc_reg <= tick_sum[17:0];
        end
    end

    // A zero count in either phase parks the output low
    logic [7:0] clk_hi;
    logic [7:0] clk_lo;
    logic [7:0] clk_cnt_reg;
    logic [7:0] clk_limit;

    assign clk_hi    = clkdiv_reg[upa_pkg::CLK_HI_LSB +: 8];
    assign clk_lo    = clkdiv_reg[upa_pkg::CLK_LO_LSB +: 8];
    assign clk_limit = clock_out ? clk_hi : clk_lo;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clock_out   <= 1'b0;
            clk_cnt_reg <= 8'h00;
        end else if (clk_hi == 8'h00 || clk_lo == 8'h00) begin
            clock_out   <= 1'b0;
            clk_cnt_reg <= 8'h00;
        end else if (tick_en) begin
            if (clk_cnt_reg + 8'h01 >= clk_limit) begin
                clock_out   <= ~clock_out;
                clk_cnt_reg <= 8'h00;
            end else begin
                clk_cnt_reg <= clk_cnt_reg + 8'h01;
            end
        end
    end

    // Remote wakeup on falling edges of enabled input pins
    assign wake_hits = {wake_sel_reg[upa_pkg::WAKE_RX_BIT] & rx_is_input & rx_fall,
                        wake_sel_reg[upa_pkg::WAKE_RING_BIT] & ring_is_input
                        & ring_fall};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_event <= 1'b0;
        end else begin
            wake_event <= |wake_hits;
        end
    end

    // Sticky wake sources, write one to clear; a new event beats the clear
    always_comb begin
        wake_sts_next = wake_sts_reg;
        if (reg_wr && addr_ok && reg_idx == upa_pkg::IDX_WAKE_STS) begin
            wake_sts_next = wake_sts_reg & ~masked(reg_wdata, upa_pkg::MSK_WAKE_STS);
        end
        wake_sts_next[upa_pkg::WAKE_RX_BIT]   = wake_sts_next[upa_pkg::WAKE_RX_BIT]
                                                | wake_hits[1];
        wake_sts_next[upa_pkg::WAKE_RING_BIT] = wake_sts_next[upa_pkg::WAKE_RING_BIT]
                                                | wake_hits[0];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_sts_reg <= 16'h0000;
        end else begin
            wake_sts_reg <= wake_sts_next;
        end
    end
endmodule

// *** tb/upa_pin_config_sva.sv ***
// Assertions on the pad, wake and clock-out ports of the configuration bank.
// Assumes one clk_sys domain with synchronous active-high rst; bound below.
`timescale 1ns/1ps
module upa_pin_config_sva (
    input wire logic                    clk_sys,      // System clock
    input wire logic                    rst,          // Synchronous reset
    input wire logic [9:0]              gpio_dir,     // GPIO direction
    input wire logic [9:0]              gpio_level,   // GPIO wanted level
    input wire upa_pkg::upa_gpio_pad_t  gpio_pad,     // GPIO pad drive
    input wire upa_pkg::upa_pin_drive_t tx_pad,       // TX pad drive
    input wire logic                    rx_pull_up,   // RX pull-up
    input wire logic                    rx_pull_down, // RX pull-down
    input wire logic                    wake_event,   // Wake pulse
    input wire logic                    clock_out     // Output clock
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // One interval spans more than eight system cycles
    sequence s_clk_edge; $changed(clock_out); endsequence
    sequence s_clk_hold; $stable(clock_out) [*7]; endsequence
    property p_clk_phase; s_clk_edge |=> s_clk_hold; endproperty
    a_clk_phase: assert property (p_clk_phase)
        else $error("clock_out phase shorter than one interval");
    property p_wake_pulse; wake_event |=> !wake_event; endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake_event longer than one cycle");
    property p_gpio_oe; (gpio_pad.oe & ~$past(gpio_dir)) == 10'h000; endproperty
    a_gpio_oe: assert property (p_gpio_oe)
        else $error("GPIO driven while not an output");
    property p_gpio_drive;
        ((gpio_pad.oe & ~gpio_pad.out & $past(gpio_level)) |
         (gpio_pad.out & ~$past(gpio_level))) == 10'h000;
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("GPIO pad level differs from wanted level");
    property p_gpio_excl; (gpio_pad.pull_up & gpio_pad.pull_down) == 10'h000; endproperty
    a_gpio_excl: assert property (p_gpio_excl)
        else $error("GPIO pull-up and pull-down both on");
    property p_gpio_pull_in;
        ((gpio_pad.pull_up | gpio_pad.pull_down) & $past(gpio_dir)) == 10'h000;
    endproperty
    a_gpio_pull_in: assert property (p_gpio_pull_in)
        else $error("GPIO pull on an output pin");
    property p_rx_excl; !(rx_pull_up && rx_pull_down); endproperty
    a_rx_excl: assert property (p_rx_excl)
        else $error("RX pull-up and pull-down both on");
    property p_tx_od; tx_pad.out |-> tx_pad.oe; endproperty
    a_tx_od: assert property (p_tx_od)
        else $error("TX high level without drive enable");
endmodule

bind upa_pin_config upa_pin_config_sva u_upa_pin_config_sva (.*);

// *** tb/upa_pad_model.sv ***
// Board and peripheral model: resolves pad levels from drives and pulls.
// Assumes an undriven, unpulled GPIO floats; modelled as a toggling level.
`timescale 1ns/1ps
module upa_pad_model (
    input wire logic                   clk_sys,      // System clock
    input wire upa_pkg::upa_gpio_pad_t gpio_pad,     // GPIO pad drive
    input wire logic                   rx_pull_up,   // RX pull-up
    input wire logic                   rx_pull_down, // RX pull-down
    input wire logic                   rx_drv,       // Peripheral drives RX
    input wire logic                   rx_lvl,       // Peripheral RX level
    input wire logic                   ring_lvl,     // Ring/wake level
    input wire logic                   dsr_lvl,      // DSR level
    input wire logic                   cts_lvl,      // CTS level
    output logic [9:0]                 gpio_pad_in,  // GPIO wire levels
    output logic                       rx_pad_in,    // RX wire level
    output logic                       ring_pad_in,  // Ring wire level
    output logic                       dsr_pad_in,   // DSR wire level
    output logic                       cts_pad_in    // CTS wire level
);
    logic flt = 1'b0;
    // A floating wire must not settle to a convenient value
    always @(posedge clk_sys) flt <= ~flt;
    assign gpio_pad_in = (gpio_pad.oe & gpio_pad.out) |
        (~gpio_pad.oe & (gpio_pad.pull_up | (~gpio_pad.pull_down & {10{flt}})));
    assign rx_pad_in = rx_drv ? rx_lvl : (rx_pull_up | (~rx_pull_down & flt));
    assign ring_pad_in = ring_lvl;
    assign dsr_pad_in = dsr_lvl;
    assign cts_pad_in = cts_lvl;
endmodule

// *** tb/tb_upa_pin_config.sv ***
// Self-checking bench for the configuration bank over its register port.
// Assumes the pad model on the far side and the bound checker.
`timescale 1ns/1ps
module tb_upa_pin_config;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [9:0] gpio_dir = 10'h000, gpio_level = 10'h2AA, gpio_pad_in, gpio_in;
    upa_pkg::upa_gpio_pad_t gpio_pad;
    upa_pkg::upa_pin_drive_t tx_pad;
    logic tx_data = 1'b1, ir_tick16 = 1'b0, ir_bit_start = 1'b0;
    logic rx_is_input = 1'b1, ring_is_input = 1'b1, dtr_out = 1'b0, rts_out = 1'b0;
    logic rx_drv = 1'b1, rx_lvl = 1'b1, ring_lvl = 1'b1;
    logic rx_pad_in, rx_pull_up, rx_pull_down, rx_data, dsr_pad_in, cts_pad_in;
    logic dsr_in, cts_in, ring_pad_in, wake_event, clock_out;
    int failures = 0, compares = 0, cyc = 0, n, k;
    logic [7:0] ad [8] = '{8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60, 8'h7C, 8'h80};
    logic [15:0] rv [8] = '{16'h0080, 16'h07FF, 16'h0000, 16'h0000, 16'h0000,
                            16'h0000, 16'h0004, 16'h0000};
    logic [15:0] mk [7] = '{16'h0BFF, 16'h07FF, 16'h07FF, 16'h0007, 16'h0007,
                            16'hFFFF, 16'h000C};

    upa_pin_config u_upa_pin_config (.*);
    upa_pad_model u_upa_pad_model (.*, .dsr_lvl(1'b0), .cts_lvl(1'b0));

    always #2.5 clk_sys = ~clk_sys;

    task end_of_test;
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard well above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task wait_n(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask
    // Tick every cycle after the bit start, so width counts in cycles
    task ir_pulse(input logic [15:0] w);
        n = 0;
        @(posedge clk_sys);
        ir_bit_start <= 1'b1; tx_data <= 1'b0;
        @(posedge clk_sys);
        ir_bit_start <= 1'b0; ir_tick16 <= 1'b1;
        repeat (14) begin
            @(posedge clk_sys);
            #1 n += tx_pad.out;
        end
        ir_tick16 <= 1'b0; tx_data <= 1'b1;
        check(n, w);
    endtask
    task wake(input logic on_rx, input logic [15:0] exp);
        n = 0;
        @(posedge clk_sys);
        if (on_rx) rx_lvl <= 1'b0;
        else ring_lvl <= 1'b0;
        repeat (12) begin
            @(posedge clk_sys);
            #1 n += wake_event;
        end
        rx_lvl <= 1'b1; ring_lvl <= 1'b1;
        wait_n(10);
        check(n, exp);
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(ad[i], rv[i]);
        check({rx_pull_up, rx_pull_down, gpio_pad.pull_up}, 16'h0BFF);
        check(gpio_in, 10'h3FF);
        for (int i = 0; i < 7; i++) begin
            wr(ad[i], mk[i]);
            rd(ad[i], mk[i]);
        end
        for (int i = 0; i < 7; i++) wr(ad[i], rv[i]);
        wr(8'h04, 16'hFFFF);
        rd(8'h04, 16'h0000);
        wr(8'h59, 16'h0007);
        rd(8'h58, 16'h0000);
        gpio_dir <= 10'h3FF;
        wait_n(3);
        check({gpio_pad.out, gpio_pad.oe}, {10'h22A, 10'h37F});
        wr(8'h4C, 16'h03FF);
        wait_n(2);
        check({gpio_pad.out, gpio_pad.oe}, {10'h000, 10'h155});
        wr(8'h4C, 16'h0800);
        wait_n(2);
        check({tx_pad, gpio_pad.out, gpio_pad.oe}, {2'b00, 10'h2AA, 10'h3FF});
        tx_data <= 1'b0;
        wait_n(2);
        check(tx_pad, 2'b01);
        wr(8'h4C, 16'h0000);
        tx_data <= 1'b1;
        gpio_dir <= 10'h00F;
        wr(8'h50, 16'h0155);
        wr(8'h54, 16'h07FF);
        wait_n(8);
        check({gpio_pad.pull_up, rx_pull_up, rx_pull_down}, {10'h150, 2'b01});
        check(gpio_pad.pull_down, 10'h2A0);
        check(gpio_in, 10'h15A);
        wr(8'h50, 16'h07FF);
        wr(8'h54, 16'h0000);
        wr(8'h58, 16'h0007);
        dtr_out <= 1'b1; rts_out <= 1'b1; tx_data <= 1'b0;
        wait_n(3);
        check({dsr_in, cts_in, rx_data, tx_pad}, 5'b11011);
        wr(8'h58, 16'h0000);
        wait_n(8);
        check({dsr_in, cts_in, rx_data, tx_pad}, 5'b00101);
        dtr_out <= 1'b0; rts_out <= 1'b0; tx_data <= 1'b1;
        wr(8'h5C, 16'h0001);
        ir_pulse(16'h0003);
        wr(8'h5C, 16'h0005);
        ir_pulse(16'h0004);
        wr(8'h5C, 16'h0002);
        wait_n(8);
        check(rx_data, 1'b0);
        wr(8'h5C, 16'h0000);
        wait_n(8);
        check(rx_data, 1'b1);
        wake(1'b0, 16'h0001);
        rd(8'h80, 16'h0004);
        wr(8'h80, 16'h0004);
        rd(8'h80, 16'h0000);
        wake(1'b1, 16'h0000);
        wr(8'h7C, 16'h0008);
        wake(1'b1, 16'h0001);
        wake(1'b0, 16'h0000);
        wr(8'h7C, 16'h000C);
        rx_is_input <= 1'b0; ring_is_input <= 1'b0;
        wake(1'b1, 16'h0000);
        wake(1'b0, 16'h0000);
        rx_is_input <= 1'b1; ring_is_input <= 1'b1;
        wr(8'h60, 16'h0201);
        k = 0;
        while (clock_out !== 1'b1 && k < 60) begin wait_n(1); k++; end
        n = 0;
        while (clock_out === 1'b1 && n < 60) begin wait_n(1); n++; end
        check(n >= 16 && n <= 17, 1'b1);
        k = 0;
        while (clock_out === 1'b0 && k < 60) begin wait_n(1); k++; end
        check(k >= 8 && k <= 9, 1'b1);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h60, 16'h0000);
        rd(8'h7C, 16'h0004);
        end_of_test();
    end
endmodule
